// ===== hdl/shp_handler_ctrl.sv
// system handler priority words and control/state word, AXI4-Lite slave
//
// Behaviour
// - each configurable system exception priority is a software settable 8-bit field
// - byte lanes of each priority word can be written alone
// - only priority bits 7:M are stored, low bits read zero
// - first word: protection 7:0, interconnect 15:8, operation 23:16
// - second word: supervisor call priority in bits 31:24
// - third word: tick timer 31:24, deferred service 23:16
// - enable bits 18, 17, 16 set to one enable the fault handlers
// - writing zero to an enable bit disables that handler
// - pending bits 15..12 report pending supervisor call and faults
// - software writes to pending bits set or clear pending state
// - active bits 11, 10, 8, 7 for tick, deferred, monitor, svc
// - active bits 3, 1, 0 for faults; bit 2 reserved
// - software writes to active bits change the active state
// - a fault whose handler is disabled escalates to hard fault
`timescale 1ns/1ps
`include "shp_defines.svh"
module shp_handler_ctrl
  import shp_pkg::*;
#(
  parameter int PRI_BITS = `SHP_PRI_BITS
) (
  input  wire logic        sys_clk_i,      // core clock
  input  wire logic        arst_n_i,       // async reset, active low
  input  wire logic        clk_en_i,       // freezes all state when low
  input  wire logic        awvalid_i,      // write address valid
  output logic             awready_o,      // write address ready
  input  wire logic [7:0]  awaddr_i,       // write byte address
  input  wire logic        wvalid_i,       // write data valid
  output logic             wready_o,       // write data ready
  input  wire logic [31:0] wdata_i,        // write data
  input  wire logic [3:0]  wstrb_i,        // write byte strobes
  output logic             bvalid_o,       // write response valid
  input  wire logic        bready_i,       // write response ready
  output logic [1:0]       bresp_o,        // write response
  input  wire logic        arvalid_i,      // read address valid
  output logic             arready_o,      // read address ready
  input  wire logic [7:0]  araddr_i,       // read byte address
  output logic             rvalid_o,       // read data valid
  input  wire logic        rready_i,       // read data ready
  output logic [31:0]      rdata_o,        // read data
  output logic [1:0]       rresp_o,        // read response
  input  wire shp_fault_s  fault_i,        // core: fault raised, pulse
  input  wire shp_pend_s   pend_set_i,     // core: set pending, pulse
  input  wire shp_pend_s   pend_clr_i,     // core: clear pending, pulse
  input  wire shp_act_s    act_set_i,      // core: exception entry, pulse
  input  wire shp_act_s    act_clr_i,      // core: exception return, pulse
  output logic [7:0]       pr_pri_o,       // protection fault priority
  output logic [7:0]       ic_pri_o,       // interconnect fault priority
  output logic [7:0]       op_pri_o,       // operation fault priority
  output logic [7:0]       svc_pri_o,      // supervisor call priority
  output logic [7:0]       def_pri_o,      // deferred service priority
  output logic [7:0]       tick_pri_o,     // tick timer priority
  output shp_fault_s       fault_en_o,     // fault handler enables
  output shp_pend_s        pend_o,         // pending flags
  output shp_act_s         act_o,          // active flags
  output logic             hard_fault_o,   // escalated fault, one cycle
  output logic             irq_o           // unmasked status level
);

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture: address and data accepted in either order

  logic             aw_held_reg;
  logic             w_held_reg;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             wr_fire;
  logic [PRI_BITS-1:0] pri_reg [6];
  shp_fault_s       en_reg;
  shp_pend_s        pend_reg;
  shp_act_s         act_reg;
  logic [`SHP_EV_WIDTH-1:0] stat_reg;
  logic [`SHP_EV_WIDTH-1:0] mask_reg;
  logic             hf_reg;

  assign awready_o = !aw_held_reg && !bvalid_o;
  assign wready_o  = !w_held_reg && !bvalid_o;
  assign wr_fire   = aw_held_reg && w_held_reg && !bvalid_o;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else if (clk_en_i) begin
      if (awvalid_i && awready_o) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr_i;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata_i;
        w_strb_reg <= wstrb_i;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // word index decode, shared by read and write
  function automatic logic [2:0] word_sel(input logic [7:0] a);
    case ({a[7:2], 2'b00})
      `SHP_OFF_FAULT_PRI: word_sel = 3'h0;
      `SHP_OFF_SVC_PRI:   word_sel = 3'h1;
      `SHP_OFF_TICK_PRI:  word_sel = 3'h2;
      `SHP_OFF_CTRL:      word_sel = 3'h3;
      `SHP_OFF_IRQ_STAT:  word_sel = 3'h4;
      `SHP_OFF_IRQ_MASK:  word_sel = 3'h5;
      default:            word_sel = 3'h7;
    endcase
  endfunction

  logic [2:0] wsel;
  assign wsel = word_sel(aw_addr_reg);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= `SHP_RESP_OKAY;
    end else if (clk_en_i) begin
      if (wr_fire) begin
        bvalid_o <= 1'b1;
        bresp_o  <= (wsel == 3'h7) ? `SHP_RESP_SLVERR : `SHP_RESP_OKAY;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority fields: index 0 pr, 1 ic, 2 op, 3 svc, 4 def, 5 tick

  // word and byte lane of each stored priority field
  function automatic logic [4:0] pri_loc(input int i);
    case (i)
      0:       pri_loc = {3'h0, 2'd0};
      1:       pri_loc = {3'h0, 2'd1};
      2:       pri_loc = {3'h0, 2'd2};
      3:       pri_loc = {3'h1, 2'd3};
      4:       pri_loc = {3'h2, 2'd2};
      default: pri_loc = {3'h2, 2'd3};
    endcase
  endfunction

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 6; i++) pri_reg[i] <= '0;
    end else if (clk_en_i && wr_fire) begin
      for (int i = 0; i < 6; i++) begin
        if (wsel == 3'(pri_loc(i) >> 2) && w_strb_reg[2'(pri_loc(i))]) begin
          // only the upper bits are kept
          pri_reg[i] <= w_data_reg[2'(pri_loc(i))*8 + 8 - PRI_BITS +:
                                   PRI_BITS];
        end
      end
    end
  end

  function automatic logic [7:0] pri8(input logic [PRI_BITS-1:0] p);
    pri8 = {p, {(8-PRI_BITS){1'b0}}};
  endfunction

  assign pr_pri_o   = pri8(pri_reg[0]);
  assign ic_pri_o   = pri8(pri_reg[1]);
  assign op_pri_o   = pri8(pri_reg[2]);
  assign svc_pri_o  = pri8(pri_reg[3]);
  assign def_pri_o  = pri8(pri_reg[4]);
  assign tick_pri_o = pri8(pri_reg[5]);

  ////////////////////////////////////////////////////////////////////////////
  // control/state word

  logic ctl_wr2, ctl_wr1, ctl_wr0;
  assign ctl_wr2 = wr_fire && wsel == 3'h3 && w_strb_reg[2];
  assign ctl_wr1 = wr_fire && wsel == 3'h3 && w_strb_reg[1];
  assign ctl_wr0 = wr_fire && wsel == 3'h3 && w_strb_reg[0];

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_reg <= '0;
    end else if (clk_en_i && ctl_wr2) begin
      en_reg <= {w_data_reg[`SHP_BIT_OP_EN],
                 w_data_reg[`SHP_BIT_IC_EN],
                 w_data_reg[`SHP_BIT_PR_EN]};
    end
  end

  // software write overrides, then core events; core set wins over clear
  shp_pend_s pend_next;
  shp_act_s  act_next;
  always_comb begin
    pend_next = pend_reg;
    if (ctl_wr1) begin
      pend_next = {w_data_reg[`SHP_BIT_SVC_PEND],
                   w_data_reg[`SHP_BIT_IC_PEND],
                   w_data_reg[`SHP_BIT_PR_PEND],
                   w_data_reg[`SHP_BIT_OP_PEND]};
    end
    pend_next = (pend_next & ~pend_clr_i) | pend_set_i;
    // an enabled fault becomes pending
    pend_next.ic = pend_next.ic | (fault_i.ic & en_reg.ic);
    pend_next.pr = pend_next.pr | (fault_i.pr & en_reg.pr);
    pend_next.op = pend_next.op | (fault_i.op & en_reg.op);
  end

  always_comb begin
    act_next = act_reg;
    if (ctl_wr1) begin
      act_next.tick = w_data_reg[`SHP_BIT_TICK_ACT];
      act_next.def  = w_data_reg[`SHP_BIT_DEF_ACT];
      act_next.mon  = w_data_reg[`SHP_BIT_MON_ACT];
    end
    if (ctl_wr0) begin
      act_next.svc = w_data_reg[`SHP_BIT_SVC_ACT];
      act_next.op  = w_data_reg[`SHP_BIT_OP_ACT];
      act_next.ic  = w_data_reg[`SHP_BIT_IC_ACT];
      act_next.pr  = w_data_reg[`SHP_BIT_PR_ACT];
    end
    act_next = (act_next & ~act_clr_i) | act_set_i;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_reg <= '0;
      act_reg  <= '0;
    end else if (clk_en_i) begin
      pend_reg <= pend_next;
      act_reg  <= act_next;
    end
  end

  // a fault on a disabled handler escalates
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hf_reg <= 1'b0;
    end else if (clk_en_i) begin
      hf_reg <= |(fault_i & ~en_reg);
    end
  end

  assign fault_en_o   = en_reg;
  assign pend_o       = pend_reg;
  assign act_o        = act_reg;
  assign hard_fault_o = hf_reg;

  ////////////////////////////////////////////////////////////////////////////
  // event status and mask: escalation and software-visible pend from core

  logic [`SHP_EV_WIDTH-1:0] ev;
  assign ev[`SHP_EV_ESCALATE] = |(fault_i & ~en_reg);
  assign ev[`SHP_EV_PEND]     = |(fault_i & en_reg);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else if (clk_en_i) begin
      if (wr_fire && wsel == 3'h4 && w_strb_reg[0]) begin
        stat_reg <= (stat_reg & ~w_data_reg[`SHP_EV_WIDTH-1:0]) | ev;
      end else begin
        stat_reg <= stat_reg | ev;
      end
      if (wr_fire && wsel == 3'h5 && w_strb_reg[0]) begin
        mask_reg <= w_data_reg[`SHP_EV_WIDTH-1:0];
      end
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  logic [31:0] rd_word;
  logic [2:0]  rsel;
  assign rsel      = word_sel(araddr_i);
  assign arready_o = !rvalid_o;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rsel)
      3'h0: rd_word = {8'h00, op_pri_o, ic_pri_o, pr_pri_o};
      3'h1: rd_word = {svc_pri_o, 24'h00_0000};
      3'h2: rd_word = {tick_pri_o, def_pri_o, 16'h0000};
      3'h3: begin
        rd_word[`SHP_BIT_OP_EN]    = en_reg.op;
        rd_word[`SHP_BIT_IC_EN]    = en_reg.ic;
        rd_word[`SHP_BIT_PR_EN]    = en_reg.pr;
        rd_word[`SHP_BIT_SVC_PEND] = pend_reg.svc;
        rd_word[`SHP_BIT_IC_PEND]  = pend_reg.ic;
        rd_word[`SHP_BIT_PR_PEND]  = pend_reg.pr;
        rd_word[`SHP_BIT_OP_PEND]  = pend_reg.op;
        rd_word[`SHP_BIT_TICK_ACT] = act_reg.tick;
        rd_word[`SHP_BIT_DEF_ACT]  = act_reg.def;
        rd_word[`SHP_BIT_MON_ACT]  = act_reg.mon;
        rd_word[`SHP_BIT_SVC_ACT]  = act_reg.svc;
        rd_word[`SHP_BIT_OP_ACT]   = act_reg.op;
        rd_word[`SHP_BIT_IC_ACT]   = act_reg.ic;
        rd_word[`SHP_BIT_PR_ACT]   = act_reg.pr;
      end
      3'h4: rd_word[`SHP_EV_WIDTH-1:0] = stat_reg;
      3'h5: rd_word[`SHP_EV_WIDTH-1:0] = mask_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h0000_0000;
      rresp_o  <= `SHP_RESP_OKAY;
    end else if (clk_en_i) begin
      if (arvalid_i && arready_o) begin
        rvalid_o <= 1'b1;
        rdata_o  <= rd_word;
        rresp_o  <= (rsel == 3'h7) ? `SHP_RESP_SLVERR : `SHP_RESP_OKAY;
      end else if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_ctrl_write;
    wr_fire && wsel == 3'h3;
  endsequence

  AST_PRI_LOW_ZERO: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    pr_pri_o[7-PRI_BITS:0] == '0 && tick_pri_o[7-PRI_BITS:0] == '0)
    else $error("low priority bits not zero");
  AST_PRI_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i && wr_fire && wsel == 3'h1 && w_strb_reg[3] |=>
    svc_pri_o[7:8-PRI_BITS] == $past(w_data_reg[31:32-PRI_BITS]))
    else $error("supervisor priority not stored");
  AST_PRI_HOLD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i && !(wr_fire && wsel == 3'h0) |=> $stable(pr_pri_o))
    else $error("priority changed without write");
  AST_EN_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i ##0 s_ctrl_write ##0 w_strb_reg[2] |=>
    fault_en_o.ic == $past(w_data_reg[`SHP_BIT_IC_EN]))
    else $error("enable bit not written");
  AST_EN_OFF: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i ##0 s_ctrl_write ##0 w_strb_reg[2] &&
    !w_data_reg[`SHP_BIT_PR_EN] |=> !fault_en_o.pr)
    else $error("enable bit not cleared");
  AST_ESCALATE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i && fault_i.op && !fault_en_o.op |=> hard_fault_o)
    else $error("disabled fault not escalated");
  AST_NO_ESCALATE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i && !(|(fault_i & ~fault_en_o)) |=> !hard_fault_o)
    else $error("spurious escalation");
  AST_PEND_SET: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i && pend_set_i.svc |=> pend_o.svc)
    else $error("pending set lost");
  AST_ACT_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i ##0 s_ctrl_write ##0 w_strb_reg[0] && !act_set_i.pr &&
    !act_clr_i.pr |=> act_o.pr == $past(w_data_reg[`SHP_BIT_PR_ACT]))
    else $error("active bit not written");
  AST_RSV_READ: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i && arvalid_i && arready_o && rsel == 3'h3 |=>
    rdata_o[31:19] == '0 && !rdata_o[9] && rdata_o[6:4] == '0 &&
    !rdata_o[2])
    else $error("reserved bits not zero");
  AST_PEND_READ: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i && arvalid_i && arready_o && rsel == 3'h3 |=>
    rdata_o[`SHP_BIT_IC_PEND] == $past(pend_o.ic))
    else $error("pending read mismatch");
  AST_ACT_READ: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    clk_en_i && arvalid_i && arready_o && rsel == 3'h3 |=>
    rdata_o[`SHP_BIT_MON_ACT] == $past(act_o.mon) &&
    rdata_o[`SHP_BIT_OP_ACT] == $past(act_o.op))
    else $error("active read mismatch");

endmodule

// ===== hdl/shp_defines.svh
// constants of the system handler priority and control block
`ifndef SHP_DEFINES_SVH
`define SHP_DEFINES_SVH
`define SHP_OFF_FAULT_PRI    8'h00
`define SHP_OFF_SVC_PRI      8'h04
`define SHP_OFF_TICK_PRI     8'h08
`define SHP_OFF_CTRL         8'h0C
`define SHP_OFF_IRQ_STAT     8'h10
`define SHP_OFF_IRQ_MASK     8'h14
`define SHP_PRI_BITS         4
`define SHP_BIT_OP_EN        18
`define SHP_BIT_IC_EN        17
`define SHP_BIT_PR_EN        16
`define SHP_BIT_SVC_PEND     15
`define SHP_BIT_IC_PEND      14
`define SHP_BIT_PR_PEND      13
`define SHP_BIT_OP_PEND      12
`define SHP_BIT_TICK_ACT     11
`define SHP_BIT_DEF_ACT      10
`define SHP_BIT_MON_ACT      8
`define SHP_BIT_SVC_ACT      7
`define SHP_BIT_OP_ACT       3
`define SHP_BIT_IC_ACT       1
`define SHP_BIT_PR_ACT       0
`define SHP_RESP_OKAY        2'h0
`define SHP_RESP_SLVERR      2'h2
`define SHP_EV_ESCALATE      0
`define SHP_EV_PEND          1
`define SHP_EV_WIDTH         2
`endif

// ===== hdl/shp_pkg.sv
// types of the system handler priority and control block
package shp_pkg;
  // one fault indication per configurable fault: operation, interconnect,
  // protection
  typedef struct packed {
    logic op;
    logic ic;
    logic pr;
  } shp_fault_s;
  // pending flags
  typedef struct packed {
    logic svc;
    logic ic;
    logic pr;
    logic op;
  } shp_pend_s;
  // active flags
  typedef struct packed {
    logic tick;
    logic def;
    logic mon;
    logic svc;
    logic op;
    logic ic;
    logic pr;
  } shp_act_s;
endpackage

// ===== bench/shp_core_model.sv
// core-side model: fault, exception entry and exception return pulses
`timescale 1ns/1ps
module shp_core_model
  import shp_pkg::*;
(
  input  wire logic sys_clk_i,  // core clock
  output shp_fault_s fault_o,    // fault raised
  output shp_pend_s  pend_set_o, // set pending
  output shp_pend_s  pend_clr_o, // clear pending
  output shp_act_s   act_set_o,  // exception entry
  output shp_act_s   act_clr_o   // exception return
);
  initial begin
    fault_o    = '0;
    pend_set_o = '0;
    pend_clr_o = '0;
    act_set_o  = '0;
    act_clr_o  = '0;
  end

  ////////////////////////////////////////////////////////////
  // one-cycle pulse; faults are raised whatever the enables say
  task automatic pulse(input shp_fault_s f, input shp_pend_s ps, pc,
                       input shp_act_s as, ac);
    @(posedge sys_clk_i);
    fault_o    <= f;
    pend_set_o <= ps;
    pend_clr_o <= pc;
    act_set_o  <= as;
    act_clr_o  <= ac;
    @(posedge sys_clk_i);
    fault_o    <= '0;
    pend_set_o <= '0;
    pend_clr_o <= '0;
    act_set_o  <= '0;
    act_clr_o  <= '0;
  endtask
endmodule

// ===== bench/shp_handler_ctrl_test.sv
// self-checking bench of the handler priority and control block
`timescale 1ns/1ps
`include "shp_defines.svh"
module shp_handler_ctrl_test
  import shp_pkg::*;
;
  localparam int          PB = 3;
  localparam logic [7:0]  FM = 8'(8'hFF << (8 - PB));
  localparam logic [31:0] CM = 32'h0007FD8B;
  localparam logic [1:0]  OK = `SHP_RESP_OKAY;
  localparam logic [1:0]  ER = `SHP_RESP_SLVERR;
  logic        sys_clk_i, arst_n_i, clk_en_i, awvalid_i, wvalid_i;
  logic        bready_i, arvalid_i, rready_i, hard_fault_o, irq_o;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [7:0]  awaddr_i, araddr_i, pr_pri_o, ic_pri_o, op_pri_o;
  logic [7:0]  svc_pri_o, def_pri_o, tick_pri_o;
  logic [31:0] wdata_i, rdata_o, rd, sv;
  logic [31:0] wm [3];
  logic [3:0]  wstrb_i;
  logic [1:0]  bresp_o, rresp_o;
  shp_fault_s  fault_i, fault_en_o;
  shp_pend_s   pend_set_i, pend_clr_i, pend_o;
  shp_act_s    act_set_i, act_clr_i, act_o;
  int          error_cnt, comparisons;
  int          abit [7] = '{0, 1, 3, 7, 8, 10, 11};

  shp_handler_ctrl #(.PRI_BITS(PB)) dut (.*);
  shp_core_model core (
    .sys_clk_i  (sys_clk_i),
    .fault_o    (fault_i),
    .pend_set_o (pend_set_i),
    .pend_clr_o (pend_clr_i),
    .act_set_o  (act_set_i),
    .act_clr_o  (act_clr_i)
  );

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic hang();
    chk("bus handshake", 32'h1, 32'h0);
    report_and_stop();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    awaddr_i  <= a;
    wdata_i   <= d;
    wstrb_i   <= s;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    bready_i  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) wvalid_i <= 1'b0;
    end while (!bvalid_o && n < 50);
    bready_i <= 1'b0;
    if (!bvalid_o) hang();
    chk("write response", 32'(er), 32'(bresp_o));
  endtask

  // read, compare data and response, keep the data in rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (arvalid_i && arready_o) arvalid_i <= 1'b0;
    end while (!rvalid_o && n < 50);
    rready_i <= 1'b0;
    if (!rvalid_o) hang();
    rd = rdata_o;
    chk("read data", exp, rdata_o);
    chk("read response", 32'(er), 32'(rresp_o));
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    {arst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = '0;
    clk_en_i    = 1'b1;
    error_cnt   = 0;
    comparisons = 0;
    wm[0] = {8'h00, FM, FM, FM};
    wm[1] = {FM, 24'h0};
    wm[2] = {FM, FM, 16'h0};
    repeat (16) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0, OK);
    foreach (wm[i]) begin
      wr(8'(4 * i), 32'hFFFFFFFF, 4'hF, OK);
      rdc(8'(4 * i), wm[i], OK);
      for (int b = 0; b < 4; b++) begin
        wr(8'(4 * i), 32'h0, 4'hF, OK);
        wr(8'(4 * i), 32'hFFFFFFFF, 4'(1 << b), OK);
        rdc(8'(4 * i), wm[i] & (32'hFF << (8 * b)), OK);
      end
    end
    wr(`SHP_OFF_FAULT_PRI, 32'h11A2C4E6, 4'hF, OK);
    wr(`SHP_OFF_SVC_PRI, 32'h9F000000, 4'hF, OK);
    wr(`SHP_OFF_TICK_PRI, 32'h6BD30000, 4'hF, OK);
    chk("protection pri", 32'(8'hE6 & FM), 32'(pr_pri_o));
    chk("interconnect pri", 32'(8'hC4 & FM), 32'(ic_pri_o));
    chk("operation pri", 32'(8'hA2 & FM), 32'(op_pri_o));
    chk("supervisor pri", 32'(8'h9F & FM), 32'(svc_pri_o));
    chk("tick pri", 32'(8'h6B & FM), 32'(tick_pri_o));
    chk("deferred pri", 32'(8'hD3 & FM), 32'(def_pri_o));
    wr(`SHP_OFF_CTRL, 32'hFFFFFFFF, 4'hF, OK);
    rdc(`SHP_OFF_CTRL, CM, OK);
    chk("enables", 32'h7, 32'(fault_en_o));
    chk("pending", 32'hF, 32'(pend_o));
    chk("active", 32'h7F, 32'(act_o));
    wr(`SHP_OFF_CTRL, 32'h0, 4'hF, OK);
    rdc(`SHP_OFF_CTRL, 32'h0, OK);
    for (int i = 0; i < 7; i++) begin
      core.pulse('0, '0, '0, shp_act_s'(7'(1) << i), '0);
      rdc(`SHP_OFF_CTRL, 32'h1 << abit[i], OK);
      core.pulse('0, '0, '0, '0, shp_act_s'(7'(1) << i));
      if (i < 4) core.pulse('0, shp_pend_s'(4'(1) << i), '0, '0, '0);
      if (i < 4) rdc(`SHP_OFF_CTRL, 32'h1 << (12 + i), OK);
      if (i < 4) core.pulse('0, '0, shp_pend_s'(4'(1) << i), '0, '0);
    end
    // kernel-style switch: save, clear, restore the active state
    core.pulse('0, '0, '0, shp_act_s'(7'h08), '0);
    rdc(`SHP_OFF_CTRL, 32'h80, OK);
    sv = rd;
    wr(`SHP_OFF_CTRL, sv & ~32'h80, 4'hF, OK);
    chk("svc active", 32'h0, 32'(act_o.svc));
    wr(`SHP_OFF_CTRL, sv, 4'hF, OK);
    chk("svc active", 32'h1, 32'(act_o.svc));
    wr(`SHP_OFF_CTRL, 32'h0, 4'hF, OK);
    core.pulse(shp_fault_s'(3'b100), '0, '0, '0, '0);
    #1 chk("escalation", 32'h1, 32'(hard_fault_o));
    chk("pending", 32'h0, 32'(pend_o));
    @(posedge sys_clk_i);
    #1 chk("escalation", 32'h0, 32'(hard_fault_o));
    rdc(`SHP_OFF_IRQ_STAT, 32'h1, OK);
    chk("irq", 32'h0, 32'(irq_o));
    wr(`SHP_OFF_IRQ_MASK, 32'h1, 4'hF, OK);
    #1 chk("irq", 32'h1, 32'(irq_o));
    wr(`SHP_OFF_IRQ_STAT, 32'h1, 4'hF, OK);
    #1 chk("irq", 32'h0, 32'(irq_o));
    rdc(`SHP_OFF_CTRL, 32'h0, OK);
    wr(`SHP_OFF_CTRL, rd | 32'h20000, 4'hF, OK);
    core.pulse(shp_fault_s'(3'b010), '0, '0, '0, '0);
    #1 chk("escalation", 32'h0, 32'(hard_fault_o));
    rdc(`SHP_OFF_CTRL, 32'h24000, OK);
    rdc(`SHP_OFF_IRQ_STAT, 32'h2, OK);
    wr(`SHP_OFF_IRQ_MASK, 32'h2, 4'hF, OK);
    #1 chk("irq", 32'h1, 32'(irq_o));
    wr(`SHP_OFF_IRQ_STAT, 32'h2, 4'hF, OK);
    rdc(`SHP_OFF_CTRL, 32'h24000, OK);
    wr(`SHP_OFF_CTRL, rd & ~32'h20000, 4'hF, OK);
    core.pulse(shp_fault_s'(3'b010), '0, '0, '0, '0);
    #1 chk("escalation", 32'h1, 32'(hard_fault_o));
    // clock enable low: a core pending request must not land
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    core.pulse('0, shp_pend_s'(4'h8), '0, '0, '0);
    chk("frozen pending", 32'h4, 32'(pend_o));
    clk_en_i <= 1'b1;
    rdc(`SHP_OFF_CTRL, 32'h4000, OK);
    rdc(8'h18, 32'h0, ER);
    wr(8'h1C, 32'hFFFFFFFF, 4'hF, ER);
    rdc(`SHP_OFF_TICK_PRI, {8'h6B & FM, 8'hD3 & FM, 16'h0}, OK);
    report_and_stop();
  end
endmodule
